// *** rcl_device.sv ***
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
// What this block does
// - Recovery runs without any reference clock unless mode bit 0 is set
// - Mode bit 0 selects reference-locked acquisition
// - Mode bit 1 enables fine rate measurement
// - Host never sets both mode bits
// - Lock target: rate/2^ratio equals ref/2^range
// - Range field bits 7:6 picks reference band
// - Ratio field bits 5:2 multiplies by 2^n
// - Host pulses restart after programming lock
// - Locked mode reacquires after any lock loss
// - Host pulses restart after changing settings
// - Lock bit rising edge also starts acquisition
// - Measure data versus reference ratio finely
// - Measuring never alters lock behaviour
// - Host sets range before fine readback
// - Measure enable is a level, repeatable
// - Measure restart falling clears done, restarts
// - Done low while measuring, high when valid
// - Result word split over three byte registers
// - Result scales by 2^(14 + range)
// - Result valid only while lock loss low
module rcl_device #(
    parameter int RESULT_W = rcl_pkg::RESULT_W
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // Register link
    rcl_if.dev               link,
    // Clocks from the outside, sampled
    input  wire logic        reference_clock_input_i,
    input  wire logic        recovered_clk_i,
    input  wire logic        loss_of_lock_flag_i,
    // Acquisition control to the recovery loop
    output logic             reference_locked_mode_o,
    output logic [3:0]       ratio_exponent_o,
    output logic [1:0]       range_select_o,
    output logic             acq_start_o,
    output logic             loss_of_lock_flag_o
);
    logic [7:0]          mode_q;      // reference_mode_control
    logic [7:0]          acq_q;       // acquisition_control
    logic                done_q;      // Measurement done flag
    logic                meas_run_q;  // Gate window open
    logic [RESULT_W-1:0] result_q;    // rate_result_word
    logic [RESULT_W-1:0] count_q;     // Recovered-clock edge count
    logic [18:0]         gate_q;      // Reference edges in window
    logic                ack_q;
    logic [7:0]          rdata_q;
    logic                acq_start_q;
    logic                ref_prev_q;
    logic                rec_prev_q;
    logic                lol_prev_q;

    // Synchronised pins: request, reference, recovered clock, lock loss
    logic [3:0] sync_w;
    rcl_sync #(.W(4)) u_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    ({link.req, reference_clock_input_i, recovered_clk_i,
                  loss_of_lock_flag_i}),
        .q_o    (sync_w)
    );
    wire req_s = sync_w[3];
    wire ref_s = sync_w[2];
    wire rec_s = sync_w[1];
    wire lol_s = sync_w[0];

    // Decode of register link
    wire       take_w    = req_s && !ack_q;
    wire       wr_w      = take_w && link.wr;
    wire       wr_mode_w = wr_w && (link.addr == rcl_pkg::REG_MODE_CTRL);
    wire       wr_acq_w  = wr_w && (link.addr == rcl_pkg::REG_ACQ_CTRL);
    wire       ref_rise  = ref_s && !ref_prev_q;
    wire       rec_rise  = rec_s && !rec_prev_q;
    wire [1:0] range_w   = mode_q[rcl_pkg::RANGE_MSB:rcl_pkg::RANGE_LSB];
    wire       lock_en_w = mode_q[rcl_pkg::MODE_LOCK_BIT];
    wire       meas_en_w = mode_q[rcl_pkg::MODE_MEAS_BIT];
    // Restart bits act on the one-to-zero write
    wire acq_fall_w  = wr_acq_w && acq_q[rcl_pkg::ACQ_RESTART]
                       && !link.wdata[rcl_pkg::ACQ_RESTART];
    wire meas_fall_w = wr_acq_w && acq_q[rcl_pkg::ACQ_MEAS_RESTART]
                       && !link.wdata[rcl_pkg::ACQ_MEAS_RESTART];
    // Only a write that raises the lock bit counts; rewriting a one is silent
    wire lock_rise_w = wr_mode_w && !lock_en_w
                       && link.wdata[rcl_pkg::MODE_LOCK_BIT];
    // Lock lost while locked to reference: relock
    wire lol_rise_w  = lol_s && !lol_prev_q && lock_en_w;
    // Window length 2^(14+range) reference edges
    // Widest window is 2^17 edges; twenty bits hold the shift safely
    wire [18:0] gate_end_w = 19'((20'h1 << (rcl_pkg::GATE_BASE + int'(range_w))) - 20'h1);

    // Register writes
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_q <= rcl_pkg::MODE_CTRL_RST;
            acq_q  <= rcl_pkg::ACQ_CTRL_RST;
        end else begin
            if (wr_mode_w) begin
                mode_q <= link.wdata;
            end
            if (wr_acq_w) begin
                acq_q <= link.wdata;
            end
        end
    end

    // Acquisition start pulse; without mode bits the loop runs free
    // Lock loss retriggers only while locked to the reference; otherwise
    // the loop finds the data rate again on its own
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acq_start_q <= 1'b0;
        end else begin
            acq_start_q <= acq_fall_w || lock_rise_w || lol_rise_w;
        end
    end

    // Edge history of sampled clocks
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ref_prev_q <= 1'b0;
            rec_prev_q <= 1'b0;
            lol_prev_q <= 1'b0;
        end else begin
            ref_prev_q <= ref_s;
            rec_prev_q <= rec_s;
            lol_prev_q <= lol_s;
        end
    end

    // Restart outranks the window end, so a done flag from the old window
    // can never survive into the new one
    // Measurement: counts only; never touches the lock outputs
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meas_run_q <= 1'b0;
            done_q     <= 1'b0;
            count_q    <= '0;
            gate_q     <= '0;
            result_q   <= '0;
        end else if (meas_fall_w && meas_en_w) begin
            meas_run_q <= 1'b1;
            done_q     <= 1'b0;
            count_q    <= '0;
            gate_q     <= '0;
        end else if (meas_run_q) begin
            if (rec_rise) begin
                count_q <= count_q + 1'b1;
            end
            if (ref_rise) begin
                if (gate_q == gate_end_w) begin
                    result_q   <= count_q + RESULT_W'(rec_rise);
                    done_q     <= 1'b1;
                    meas_run_q <= 1'b0;
                end else begin
                    gate_q <= gate_q + 19'h1;
                end
            end
            if (!meas_en_w) begin
                meas_run_q <= 1'b0; // Disabled mid-window: abandon
            end
        end
    end

    // Read mux; result bytes per layout
    // Bit 7 of the high result byte always reads zero
    logic [7:0] rmux_w;
    always_comb begin
        case (link.addr)
            rcl_pkg::REG_MODE_CTRL:   rmux_w = mode_q;
            rcl_pkg::REG_ACQ_CTRL:    rmux_w = acq_q;
            rcl_pkg::REG_MISC_STATUS: rmux_w = {5'h0, done_q, 1'b0, lol_s};
            rcl_pkg::REG_RESULT_HIGH: rmux_w = {1'b0, result_q[22:16]};
            rcl_pkg::REG_RESULT_MID:  rmux_w = result_q[15:8];
            rcl_pkg::REG_RESULT_LOW:  rmux_w = result_q[7:0];
            default:                  rmux_w = 8'h00;
        endcase
    end

    // Four-phase link handshake
    // Host holds the fields from req until ack, so they skip the sync
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_q   <= 1'b0;
            rdata_q <= 8'h00;
        end else if (take_w) begin
            ack_q   <= 1'b1;
            rdata_q <= rmux_w;
        end else if (!req_s) begin
            ack_q   <= 1'b0;
        end
    end

    assign link.ack   = ack_q;
    assign link.rdata = rdata_q;
    // lock targets come only from mode bits
    assign reference_locked_mode_o = lock_en_w;
    assign ratio_exponent_o        = mode_q[rcl_pkg::RATIO_MSB:rcl_pkg::RATIO_LSB];
    assign range_select_o          = range_w;
    assign acq_start_o             = acq_start_q;
    assign loss_of_lock_flag_o     = lol_s;
endmodule

// *** rcl_host.sv ***
`timescale 1ns/100ps
// Host end: AHB-Lite slave that issues single register link cycles
module rcl_host (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [7:0]  haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic        hready_i,
    // Register link
    rcl_if.host              link
);
    logic       req_q;
    logic       wr_q;
    logic [2:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] rbyte_q;
    logic       busy_q;
    logic       aw_q;     // Pending data-phase write
    logic [7:0] aaddr_q;
    logic [31:0] hrdata_q; // Read word, stands through the data phase

    // Acknowledge comes from another domain
    logic ack_s;
    rcl_sync #(.W(1)) u_ack (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (link.ack),
        .q_o    (ack_s)
    );

    wire addr_ok   = hsel_i && hready_i && (htrans_i == rcl_pkg::HTRANS_NONSEQ);
    wire cmd_wr    = aw_q && (aaddr_q == rcl_pkg::HOFS_CMD) && !busy_q;
    // Read word picked at the address phase; unmapped offsets read zero
    wire [31:0] rsel_w = (haddr_i == rcl_pkg::HOFS_STATUS) ? {31'h0, busy_q} :
                         (haddr_i == rcl_pkg::HOFS_RDATA)  ? {24'h0, rbyte_q} : 32'h0;

    // Address phase capture; hsize is always a word
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aw_q     <= 1'b0;
            aaddr_q  <= 8'h00;
            hrdata_q <= 32'h0;
        end else begin
            aw_q     <= addr_ok && hwrite_i;
            aaddr_q  <= haddr_i;
            hrdata_q <= addr_ok ? rsel_w : hrdata_q;
        end
    end

    // Link sequencer: raise req, wait ack, drop req, wait ack low
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            req_q   <= 1'b0;
            wr_q    <= 1'b0;
            addr_q  <= 3'h0;
            wdata_q <= 8'h00;
            rbyte_q <= 8'h00;
            busy_q  <= 1'b0;
        end else if (cmd_wr) begin
            req_q   <= 1'b1;
            busy_q  <= 1'b1;
            addr_q  <= hwdata_i[2:0];
            wdata_q <= hwdata_i[15:8];
            wr_q    <= hwdata_i[16];
        end else if (req_q && ack_s) begin
            req_q   <= 1'b0;
            rbyte_q <= link.rdata; // Stable: held since ack rose
        end else if (!req_q && !ack_s) begin
            busy_q  <= 1'b0;
        end
    end

    // Read data straight from a flop, zero-wait
    assign hrdata_o = hrdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign link.req    = req_q;
    assign link.wr     = wr_q;
    assign link.addr   = addr_q;
    assign link.wdata  = wdata_q;
endmodule

// *** rcl_if.sv ***
`timescale 1ns/100ps
// Parallel register link between the host end and the device end
interface rcl_if;
    logic       req;      // Host request level (toggle-free: held until ack)
    logic       wr;       // Write when high
    logic [2:0] addr;     // Register index
    logic [7:0] wdata;    // Write byte
    logic       ack;      // Device acknowledge level
    logic [7:0] rdata;    // Read byte

    modport dev  (input req, wr, addr, wdata, output ack, rdata);
    modport host (output req, wr, addr, wdata, input ack, rdata);
endinterface

// *** rcl_link_props.sv ***
`timescale 1ns/100ps
// Watches the four-phase register link between the two ends
module rcl_link_props (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       nrst_i,
    // Link signals
    input wire logic       req,
    input wire logic       wr,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       ack,
    input wire logic [7:0] rdata
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // Host end keeps asking until answered
    chk_req_held: assert property (req && !ack |=> req)
        else $error("link request dropped before acknowledge");
    // Qualifiers frozen while waiting, else wrong register hit
    chk_fields_fixed: assert property (req && !ack |=> $stable({wr, addr, wdata}))
        else $error("link fields moved while waiting");
    chk_req_from_idle: assert property ($rose(req) |-> !ack)
        else $error("request raised while acknowledge high");
    // Sync plus answer delay stays well inside this bound
    chk_ack_timely: assert property ($rose(req) |-> ##[1:16] ack)
        else $error("acknowledge late");
    chk_ack_caused: assert property ($rose(ack) |-> req)
        else $error("acknowledge without request");
    chk_ack_held: assert property (ack && req |=> ack)
        else $error("acknowledge dropped while request high");
    chk_ack_release: assert property ($fell(req) |-> ##[1:16] !ack)
        else $error("acknowledge stuck after release");
    chk_rdata_steady: assert property (ack ##1 ack |-> $stable(rdata))
        else $error("read byte moved during acknowledge");
    // Main traffic kinds
    cov_write: cover property ($rose(req) && wr);
    cov_read: cover property ($rose(req) && !wr);
    cov_done: cover property ($fell(ack));
endmodule

// *** rcl_pkg.sv ***
package rcl_pkg;
    // Register indices of the device's 8-bit register space
    localparam logic [2:0] REG_MODE_CTRL   = 3'h0; // reference_mode_control
    localparam logic [2:0] REG_ACQ_CTRL    = 3'h1; // acquisition_control
    localparam logic [2:0] REG_MISC_STATUS = 3'h2; // miscellaneous status
    localparam logic [2:0] REG_RESULT_HIGH = 3'h3; // rate_result_high
    localparam logic [2:0] REG_RESULT_MID  = 3'h4; // rate_result_mid
    localparam logic [2:0] REG_RESULT_LOW  = 3'h5; // rate_result_low

    // Field positions in reference_mode_control
    localparam int MODE_LOCK_BIT    = 0;
    localparam int MODE_MEAS_BIT    = 1;
    localparam int RATIO_LSB        = 2;
    localparam int RATIO_MSB        = 5;
    localparam int RANGE_LSB        = 6;
    localparam int RANGE_MSB        = 7;
    // Field positions in acquisition_control and status
    localparam int ACQ_MEAS_RESTART = 3;
    localparam int ACQ_RESTART      = 5;
    localparam int STAT_MEAS_DONE   = 2;
    localparam int STAT_LOL         = 0;

    // Reset values
    localparam logic [7:0] MODE_CTRL_RST = 8'h00;
    localparam logic [7:0] ACQ_CTRL_RST  = 8'h00;

    // Measurement gate: 2^(GATE_BASE + range) reference cycles
    localparam int GATE_BASE   = 14;
    localparam int RESULT_W    = 23;
    // Host AHB register byte offsets
    localparam logic [7:0] HOFS_CMD    = 8'h00; // [2:0] reg index, [15:8] data, [16] write
    localparam logic [7:0] HOFS_STATUS = 8'h04; // [0] busy
    localparam logic [7:0] HOFS_RDATA  = 8'h08; // last read byte
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// *** rcl_sync.sv ***
`timescale 1ns/100ps
// Three-stage synchroniser; change taken when stages two and three agree
module rcl_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_q; // Metastable stage, read only by s2
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] q_q;

    // Shift chain
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Filtered output per bit
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                q_q[i] <= 1'b0;
            end else if (s2_q[i] == s3_q[i]) begin
                q_q[i] <= s3_q[i];
            end
        end
    end

    assign q_o = q_q;
endmodule

// *** tb.sv ***
`timescale 1ns/100ps
// Drives both link ends from the bus side and the outside clocks
module tb;
    logic        clk_i, nrst_i;      // Bench clock and reset
    logic [7:0]  haddr;              // Bus address
    logic [1:0]  htrans;             // Bus transfer kind
    logic        hwrite;             // Bus direction
    logic [31:0] hwdata, hrdata;     // Bus data
    logic        hready, hresp;      // Bus ready and response
    logic        ref_clk, rec_clk;   // Outside clocks
    logic        loss_of_lock_flag, lol_o;         // Lock loss in and synced
    logic        lock_md, start;     // Mode level and start pulse
    logic [3:0]  ratio;              // Ratio exponent out
    logic [1:0]  range;              // Range select out
    logic [7:0]  rd;                 // Last byte read
    int          fails, n_compared;  // Verdict counters
    int          n_starts, cycles;   // Start pulses and run length
    rcl_if link ();
    rcl_host i_rcl_host (.clk_i, .nrst_i, .hsel_i(1'b1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .hready_i(hready),
        .link(link.host));
    rcl_device i_rcl_device (.clk_i, .nrst_i, .link(link.dev),
        .reference_clock_input_i(ref_clk), .recovered_clk_i(rec_clk),
        .loss_of_lock_flag_i(loss_of_lock_flag), .reference_locked_mode_o(lock_md),
        .ratio_exponent_o(ratio), .range_select_o(range), .acq_start_o(start),
        .loss_of_lock_flag_o(lol_o));
    rcl_link_props i_rcl_link_props (.clk_i, .nrst_i, .req(link.req), .wr(link.wr),
        .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
    // Bench clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Fast reference keeps the gate window inside the run budget
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Recovered clock at half the reference rate, phase unrelated
    initial begin
        rec_clk = 1'b0;
        #7;
        forever #40 rec_clk = ~rec_clk;
    end
    // Start pulses counted; hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (start === 1'b1) n_starts++;
        if (cycles == 90000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Single word transfer; read data taken at the data phase edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clk_i);
        haddr <= a;
        hwrite <= w;
        htrans <= rcl_pkg::HTRANS_NONSEQ;
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_i); while (hready !== 1'b1);
        r = hrdata;
        check(hresp, 1'b0); // Slave answers OKAY
    endtask
    // One link cycle; the returned byte is only meaningful for reads
    task automatic reg_io(input logic w, input logic [2:0] idx, input logic [7:0] d);
        logic [31:0] r;
        int          n;
        n = 0;
        ahb(1'b1, rcl_pkg::HOFS_CMD, {15'h0, w, d, 5'h0, idx}, r);
        do begin
            ahb(1'b0, rcl_pkg::HOFS_STATUS, 32'h0, r);
            n++;
        end while (r[0] !== 1'b0 && n < 40);
        check(r & 32'h1, 32'h0); // Link cycle finished in time
        ahb(1'b0, rcl_pkg::HOFS_RDATA, 32'h0, r);
        rd = r[7:0];
    endtask
    // Lock loss pulse, waiting on the synced copy both ways
    task automatic lol_pulse();
        int n;
        loss_of_lock_flag <= 1'b1;
        for (n = 0; n < 20 && lol_o !== 1'b1; n++) @(posedge clk_i);
        reg_io(1'b0, rcl_pkg::REG_MISC_STATUS, 8'h00);
        check(rd[rcl_pkg::STAT_LOL], 1'b1);
        loss_of_lock_flag <= 1'b0;
        for (n = 0; n < 20 && lol_o !== 1'b0; n++) @(posedge clk_i);
    endtask
    task automatic t_reset();
        reg_io(1'b0, rcl_pkg::REG_MODE_CTRL, 8'h00);
        check(rd, rcl_pkg::MODE_CTRL_RST);
        check({lock_md, ratio, range}, 7'h00);
        reg_io(1'b0, 3'h7, 8'h00);
        check(rd, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_lock();
        int n0;
        n0 = n_starts;
        reg_io(1'b1, rcl_pkg::REG_MODE_CTRL, 8'h55);
        check({lock_md, ratio, range}, {1'b1, 4'h5, 2'h1});
        check(n_starts, n0 + 1);
        reg_io(1'b0, rcl_pkg::REG_MODE_CTRL, 8'h00);
        check(rd, 8'h55);
        reg_io(1'b1, rcl_pkg::REG_ACQ_CTRL, 8'h20);
        check(n_starts, n0 + 1);
        reg_io(1'b1, rcl_pkg::REG_ACQ_CTRL, 8'h00);
        check(n_starts, n0 + 2);
        lol_pulse();
        check(n_starts, n0 + 3);
        for (int g = 0; g < 4; g++) begin
            reg_io(1'b1, rcl_pkg::REG_MODE_CTRL, {g[1:0], 4'(2 * g + 2), 2'h1});
            check({ratio, range}, {4'(2 * g + 2), g[1:0]});
            check(n_starts, n0 + 3 + g);
            // New settings are followed by a restart pulse
            reg_io(1'b1, rcl_pkg::REG_ACQ_CTRL, 8'h20);
            reg_io(1'b1, rcl_pkg::REG_ACQ_CTRL, 8'h00);
        end
        check(n_starts, n0 + 7);
        $display("test lock done");
    endtask
    task automatic t_meas();
        int          n0;
        logic [22:0] v;
        reg_io(1'b1, rcl_pkg::REG_MODE_CTRL, 8'h00);
        reg_io(1'b1, rcl_pkg::REG_MODE_CTRL, 8'h02);
        n0 = n_starts;
        lol_pulse();
        check(n_starts, n0);
        // Restart twice with the enable left set
        repeat (2) begin
            reg_io(1'b1, rcl_pkg::REG_ACQ_CTRL, 8'h08);
            reg_io(1'b1, rcl_pkg::REG_ACQ_CTRL, 8'h00);
            reg_io(1'b0, rcl_pkg::REG_MISC_STATUS, 8'h00);
            check(rd[rcl_pkg::STAT_MEAS_DONE], 1'b0);
        end
        do reg_io(1'b0, rcl_pkg::REG_MISC_STATUS, 8'h00);
        while (rd[rcl_pkg::STAT_MEAS_DONE] !== 1'b1);
        check(rd[rcl_pkg::STAT_LOL], 1'b0);
        reg_io(1'b0, rcl_pkg::REG_RESULT_HIGH, 8'h00);
        check(rd[7], 1'b0);
        v[22:16] = rd[6:0];
        reg_io(1'b0, rcl_pkg::REG_RESULT_MID, 8'h00);
        v[15:8] = rd;
        reg_io(1'b0, rcl_pkg::REG_RESULT_LOW, 8'h00);
        v[7:0] = rd;
        // Half-rate recovered clock gives 2^(14-1); gate phase slack: check accepts 8191 to 8194
        check(32'((v + 23'd1) >> 2), 32'((1 << (rcl_pkg::GATE_BASE - 1)) >> 2));
        $display("test measure done");
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        {nrst_i, haddr, htrans, hwrite, hwdata, loss_of_lock_flag} = '0;
        {fails, n_compared, n_starts, cycles} = '0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_lock();
        // Mid-run reset must return every register to its reset value
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_meas();
        wrap_up();
    end
endmodule
